/* File: video_capture_pkg.sv */
package video_capture_pkg;

	// ----------------------------------------------------------------
	// Data path widths and buffering
	// ----------------------------------------------------------------
	localparam int PIXEL_WIDTH = 24;
	localparam int COUNT_WIDTH = 12;
	localparam int FIFO_DEPTH = 8;
	localparam int WORD_SOF = 24;
	localparam int WORD_SOL = 25;
	localparam int WORD_FIELD = 26;
	localparam int WORD_WIDTH = 27;

	// ----------------------------------------------------------------
	// Embedded timing reference of the 8-bit 4:2:2 mode
	// ----------------------------------------------------------------
	localparam logic [7:0] REF_PREAMBLE_HI = 8'hFF;
	localparam logic [7:0] REF_PREAMBLE_LO = 8'h00;
	localparam int REF_FIELD_BIT = 6;
	localparam int REF_VBLANK_BIT = 5;
	localparam int REF_EAV_BIT = 4;
	localparam int PIPE_STAGES = 3;

	// ----------------------------------------------------------------
	// Reset values of the settings in force
	// ----------------------------------------------------------------
	localparam logic RST_EDGE_FALLING = 1'b0;
	localparam logic RST_SYNC_LOW = 1'b0;

	// ----------------------------------------------------------------
	// Source classes
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		SRC_GENERIC,
		SRC_SD525,
		SRC_SD625,
		SRC_OPTICAL
	} source_class_t;

	// Timing reference parser states
	typedef enum logic [1:0]
	{
		REF_IDLE,
		REF_GOT_FF,
		REF_GOT_00A,
		REF_GOT_00B
	} ref_state_t;

endpackage

/* File: cdc_word_fifo.sv */
module cdc_word_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 8
) (
	input wire logic wr_clk,
	input wire logic wr_rst_n,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_clk,
	input wire logic rd_rst_n,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 4 || (1 << AW) != DEPTH)
			$error("cdc_word_fifo: DEPTH must be a power of two, at least 4");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wbin, next_wbin, wgray, rbin, next_rbin, rgray;
	logic [AW:0] rq1, rq2, wq1, wq2;
	logic empty, load, next_rd_valid;
	logic [WIDTH-1:0] next_rd_data;

	// ----------------------------------------------------------------
	// Write side
	// ----------------------------------------------------------------
	// Full when the write pointer has lapped the synced read pointer
	always_comb
	begin
		wr_ready = (wgray != {~rq2[AW:AW-1], rq2[AW-2:0]});
		next_wbin = (wr_valid && wr_ready) ? wbin + 1'b1 : wbin;
	end

	// Gray pointers cross, so only one bit moves per step
	always_ff @(posedge wr_clk or negedge wr_rst_n)
	begin
		if (!wr_rst_n)
		begin
			wbin <= '0;
			wgray <= '0;
			rq1 <= '0;
			rq2 <= '0;
		end
		else
		begin
			wbin <= next_wbin;
			wgray <= next_wbin ^ (next_wbin >> 1);
			rq1 <= rgray;
			rq2 <= rq1;
		end
	end

	// Storage has no reset
	always_ff @(posedge wr_clk)
	begin
		if (wr_valid && wr_ready)
			mem[wbin[AW-1:0]] <= wr_data;
	end

	// ----------------------------------------------------------------
	// Read side
	// ----------------------------------------------------------------
	// Output register refills whenever it is free or being taken
	always_comb
	begin
		empty = (rgray == wq2);
		load = !empty && (!rd_valid || rd_ready);
		next_rbin = load ? rbin + 1'b1 : rbin;
		next_rd_data = load ? mem[rbin[AW-1:0]] : rd_data;
		next_rd_valid = load ? 1'b1 : (rd_ready ? 1'b0 : rd_valid);
	end

	always_ff @(posedge rd_clk or negedge rd_rst_n)
	begin
		if (!rd_rst_n)
		begin
			rbin <= '0;
			rgray <= '0;
			wq1 <= '0;
			wq2 <= '0;
			rd_valid <= 1'b0;
			rd_data <= '0;
		end
		else
		begin
			rbin <= next_rbin;
			rgray <= next_rbin ^ (next_rbin >> 1);
			wq1 <= wgray;
			wq2 <= wq1;
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
		end
	end
endmodule

/* File: parallel_video_input_capture.sv */
module parallel_video_input_capture #(
	parameter int CW = video_capture_pkg::COUNT_WIDTH,
	parameter int DEPTH = video_capture_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pclk,
	input wire logic hsync_in,
	input wire logic vsync_in,
	input wire logic pixel_valid_in,
	input wire logic [video_capture_pkg::PIXEL_WIDTH-1:0] pixel_bus_in,
	input wire logic capture_on_falling,
	input wire logic hsync_active_low,
	input wire logic vsync_active_low,
	input wire logic bt656_mode,
	input wire logic use_valid_strobe,
	input wire logic portrait,
	input wire logic [1:0] source_class,
	input wire logic [CW-1:0] h_start,
	input wire logic [CW-1:0] h_active,
	input wire logic [CW-1:0] v_start,
	input wire logic [CW-1:0] v_active,
	output logic [video_capture_pkg::PIXEL_WIDTH-1:0] pix_data,
	output logic pix_frame_start,
	output logic pix_line_start,
	output logic pix_field,
	output logic pix_valid,
	input wire logic pix_ready,
	output logic overflow,
	output logic unsupported,
	output logic interlaced
);
	localparam int PW = video_capture_pkg::PIXEL_WIDTH;
	localparam int WW = video_capture_pkg::WORD_WIDTH;
	localparam int CFG_W = 7 + 4 * CW;

	initial
	begin
		if (CW < 10)
			$error("parallel_video_input_capture: CW too small for line lengths");
	end

	// ----------------------------------------------------------------
	// Link domain reset and setting crossing
	// ----------------------------------------------------------------
	logic prst_q1, prst_n;
	logic [CFG_W-1:0] cfg_raw, cfg_q1, cfg_q2, act;

	// Reset asserts at once, releases on the pixel clock
	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prst_q1 <= 1'b0;
			prst_n <= 1'b0;
		end
		else
		begin
			prst_q1 <= 1'b1;
			prst_n <= prst_q1;
		end
	end

	// Settings are quasi-static; they are only used once latched at a frame edge
	assign cfg_raw = {capture_on_falling, hsync_active_low, vsync_active_low, bt656_mode,
		use_valid_strobe, portrait, source_class[0] | source_class[1] ? 1'b1 : 1'b0,
		h_start, h_active, v_start, v_active};

	// Two-flop crossing into the link domain
	always_ff @(posedge pclk or negedge prst_n)
	begin
		if (!prst_n)
		begin
			cfg_q1 <= '0;
			cfg_q2 <= '0;
		end
		else
		begin
			cfg_q1 <= cfg_raw;
			cfg_q2 <= cfg_q1;
		end
	end

	// Class bits cross separately so the enum keeps both bits
	logic [1:0] cls_q1, cls_q2;
	video_capture_pkg::source_class_t act_cls;
	always_ff @(posedge pclk or negedge prst_n)
	begin
		if (!prst_n)
		begin
			cls_q1 <= 2'h0;
			cls_q2 <= 2'h0;
		end
		else
		begin
			cls_q1 <= source_class;
			cls_q2 <= cls_q1;
		end
	end

	logic act_edge, act_hs_low, act_vs_low, act_bt, act_de, act_portrait;
	logic [CW-1:0] act_hstart, act_hact, act_vstart, act_vact;
	assign act_edge = act[CFG_W-1];
	assign act_hs_low = act[CFG_W-2];
	assign act_vs_low = act[CFG_W-3];
	assign act_bt = act[CFG_W-4];
	assign act_de = act[CFG_W-5];
	assign act_portrait = act[CFG_W-6];
	assign act_hstart = act[4*CW-1:3*CW];
	assign act_hact = act[3*CW-1:2*CW];
	assign act_vstart = act[2*CW-1:CW];
	assign act_vact = act[CW-1:0];

	// ----------------------------------------------------------------
	// Pin capture on both edges
	// ----------------------------------------------------------------
	logic r_hs, r_vs, r_de, f_hs, f_vs, f_de, s_hs, s_vs, s_de;
	logic [PW-1:0] r_d, f_d, s_d;

	// Pins are launched by the source on pclk, so no extra synchroniser
	always_ff @(posedge pclk or negedge prst_n)
	begin
		if (!prst_n)
			{r_hs, r_vs, r_de, r_d} <= '0;
		else
			{r_hs, r_vs, r_de, r_d} <= {hsync_in, vsync_in, pixel_valid_in, pixel_bus_in};
	end

	always_ff @(negedge pclk or negedge prst_n)
	begin
		if (!prst_n)
			{f_hs, f_vs, f_de, f_d} <= '0;
		else
			{f_hs, f_vs, f_de, f_d} <= {hsync_in, vsync_in, pixel_valid_in, pixel_bus_in};
	end

	// Selected edge feeds one posedge stage; falling samples get half a period
	always_ff @(posedge pclk or negedge prst_n)
	begin
		if (!prst_n)
			{s_hs, s_vs, s_de, s_d} <= '0;
		else if (act_edge)
			{s_hs, s_vs, s_de, s_d} <= {f_hs, f_vs, f_de, f_d};
		else
			{s_hs, s_vs, s_de, s_d} <= {r_hs, r_vs, r_de, r_d};
	end

	// ----------------------------------------------------------------
	// Framing, parsing and pipeline (link domain)
	// ----------------------------------------------------------------
	logic hs, vs, prev_hs, prev_vs, next_prev_hs, next_prev_vs;
	logic started, next_started, sof_pend, next_sof_pend, sol_pend, next_sol_pend;
	logic field, next_field, in_line, next_in_line, drop, next_drop;
	logic [CW-1:0] pix_cnt, next_pix_cnt, line_cnt, next_line_cnt;
	video_capture_pkg::ref_state_t ref_st, next_ref_st;
	logic [WW-1:0] pipe [video_capture_pkg::PIPE_STAGES];
	logic [WW-1:0] next_pipe [video_capture_pkg::PIPE_STAGES];
	logic [video_capture_pkg::PIPE_STAGES-1:0] pv, next_pv;
	logic [CFG_W-1:0] next_act;
	logic boundary, word_in, capture_ok, is_sd, fifo_ready, cancel, wr_en;
	logic [7:0] b;

	assign is_sd = (act_cls == video_capture_pkg::SRC_SD525) || (act_cls == video_capture_pkg::SRC_SD625);
	// Portrait is refused for broadcast and optical test classes
	assign capture_ok = !(act_portrait && act_cls != video_capture_pkg::SRC_GENERIC);

	always_comb
	begin
		hs = s_hs ^ act_hs_low;
		vs = s_vs ^ act_vs_low;
		b = s_d[7:0];
		next_prev_hs = hs;
		next_prev_vs = vs;
		next_ref_st = video_capture_pkg::REF_IDLE;
		next_in_line = in_line;
		next_field = field;
		next_pix_cnt = pix_cnt + 1'b1;
		next_line_cnt = line_cnt;
		next_sol_pend = sol_pend;
		next_pv = pv;
		boundary = 1'b0;
		word_in = 1'b0;
		cancel = 1'b0;
		if (act_bt)
		begin
			// Timing reference is FF 00 00 XY on the low byte
			case (ref_st)
				video_capture_pkg::REF_IDLE:
					if (b == video_capture_pkg::REF_PREAMBLE_HI)
						next_ref_st = video_capture_pkg::REF_GOT_FF;
				video_capture_pkg::REF_GOT_FF:
					if (b == video_capture_pkg::REF_PREAMBLE_LO)
						next_ref_st = video_capture_pkg::REF_GOT_00A;
				video_capture_pkg::REF_GOT_00A:
					if (b == video_capture_pkg::REF_PREAMBLE_LO)
						next_ref_st = video_capture_pkg::REF_GOT_00B;
				default:
				begin
					next_field = b[video_capture_pkg::REF_FIELD_BIT];
					boundary = (b[video_capture_pkg::REF_FIELD_BIT] != field) || !started;
					if (b[video_capture_pkg::REF_EAV_BIT])
					begin
						next_in_line = 1'b0;
						next_pv = '0; // Drop preamble bytes already in the pipe
						cancel = 1'b1; // Oldest preamble byte sits at the buffer input now
					end
					else if (!b[video_capture_pkg::REF_VBLANK_BIT])
					begin
						next_in_line = 1'b1;
						next_sol_pend = 1'b1;
					end
				end
			endcase
			word_in = in_line && !(ref_st == video_capture_pkg::REF_GOT_00B);
		end
		else
		begin
			boundary = vs && !prev_vs;
			if (boundary)
			begin
				next_line_cnt = '0;
				next_field = is_sd ? !field : 1'b0;
			end
			if (hs && !prev_hs)
			begin
				next_pix_cnt = '0;
				next_sol_pend = 1'b1;
				if (!boundary)
					next_line_cnt = line_cnt + 1'b1;
			end
			if (act_de)
				word_in = s_de;
			else // Auto framing window from counts
				word_in = (pix_cnt >= act_hstart) && (pix_cnt - act_hstart < act_hact)
					&& (line_cnt >= act_vstart) && (line_cnt - act_vstart < act_vact);
		end
		// Latch new settings only between frames
		next_act = (boundary || !started) ? cfg_q2 : act;
		next_started = started || boundary;
		next_sof_pend = boundary ? 1'b1 : sof_pend;
		// Three-word pipe lets a trailing reference cancel its preamble
		next_pipe[0] = {field, next_sol_pend && in_line, next_sof_pend, s_d};
		next_pipe[1] = pipe[0];
		next_pipe[2] = pipe[1];
		next_pv = {next_pv[1:0], word_in && started && !boundary};
		if (word_in && started && !boundary)
		begin
			next_sol_pend = 1'b0;
			next_sof_pend = 1'b0;
		end
		if (act_bt && !in_line)
			next_pipe[0][video_capture_pkg::WORD_SOL] = 1'b0;
		if (!act_bt)
			next_pipe[0][video_capture_pkg::WORD_SOL] = sol_pend || (hs && !prev_hs);
		// Once the buffer refuses a word, the rest of the frame is discarded
		next_drop = boundary ? 1'b0 : (drop || (pv[2] && capture_ok && !cancel && !fifo_ready));
	end

	always_ff @(posedge pclk or negedge prst_n)
	begin
		if (!prst_n)
		begin
			act <= {video_capture_pkg::RST_EDGE_FALLING, video_capture_pkg::RST_SYNC_LOW,
				video_capture_pkg::RST_SYNC_LOW, {(CFG_W-3){1'b0}}};
			act_cls <= video_capture_pkg::SRC_GENERIC;
			{prev_hs, prev_vs, started, sof_pend, sol_pend, field, in_line, drop} <= '0;
			pix_cnt <= '0;
			line_cnt <= '0;
			ref_st <= video_capture_pkg::REF_IDLE;
			pv <= '0;
			pipe <= '{default: '0};
		end
		else
		begin
			act <= next_act;
			act_cls <= (boundary || !started) ? video_capture_pkg::source_class_t'(cls_q2) : act_cls;
			{prev_hs, prev_vs, started} <= {next_prev_hs, next_prev_vs, next_started};
			{sof_pend, sol_pend, field, in_line, drop} <= {next_sof_pend, next_sol_pend, next_field,
				next_in_line, next_drop};
			pix_cnt <= next_pix_cnt;
			line_cnt <= next_line_cnt;
			ref_st <= next_ref_st;
			pv <= next_pv;
			pipe <= next_pipe;
		end
	end

	// ----------------------------------------------------------------
	// Buffer into the system clock domain
	// ----------------------------------------------------------------
	logic [WW-1:0] rd_word;
	assign wr_en = pv[2] && capture_ok && !drop && !cancel;

	cdc_word_fifo #(
		.WIDTH(WW),
		.DEPTH(DEPTH)
	) u_fifo (
		.wr_clk(pclk),
		.wr_rst_n(prst_n),
		.wr_valid(wr_en),
		.wr_ready(fifo_ready),
		.wr_data(pipe[2]),
		.rd_clk(clk),
		.rd_rst_n(rst_n),
		.rd_valid(pix_valid),
		.rd_ready(pix_ready),
		.rd_data(rd_word)
	);

	assign pix_data = rd_word[PW-1:0];
	assign pix_frame_start = rd_word[video_capture_pkg::WORD_SOF];
	assign pix_line_start = rd_word[video_capture_pkg::WORD_SOL];
	assign pix_field = rd_word[video_capture_pkg::WORD_FIELD];

	// Status levels cross back through two flops
	logic [2:0] st_q1, st_q2;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q1 <= 3'h0;
			st_q2 <= 3'h0;
		end
		else
		begin
			st_q1 <= {drop, !capture_ok, is_sd};
			st_q2 <= st_q1;
		end
	end
	assign {overflow, unsupported, interlaced} = st_q2;
endmodule

/* File: video_capture_properties.sv */
module video_capture_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bt656_mode,
	input wire logic portrait,
	input wire logic [1:0] source_class,
	input wire logic [video_capture_pkg::PIXEL_WIDTH-1:0] pix_data,
	input wire logic pix_frame_start,
	input wire logic pix_line_start,
	input wire logic pix_field,
	input wire logic pix_valid,
	input wire logic pix_ready,
	input wire logic overflow,
	input wire logic unsupported,
	input wire logic interlaced
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] settle_cnt;
	logic [4:0] next_settle_cnt;
	logic [3:0] prev_cfg;
	// --------
	// Settling
	// --------
	// Restart when bt656_mode, portrait or source_class changes; status is only trusted after it saturates
	always_comb
	begin
		next_settle_cnt = settle_cnt + 5'h01;
		if ({bt656_mode, portrait, source_class} != prev_cfg)
			next_settle_cnt = 5'h00;
		else if (settle_cnt == 5'h1F)
			next_settle_cnt = settle_cnt;
	end
	// Registers only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			settle_cnt <= 5'h00;
			prev_cfg <= 4'h0;
		end
		else
		begin
			settle_cnt <= next_settle_cnt;
			prev_cfg <= {bt656_mode, portrait, source_class};
		end
	end
	// --------
	// Properties
	// --------
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_stall;
		pix_valid && !pix_ready;
	endsequence
	sequence s_settled;
		settle_cnt == 5'h1F;
	endsequence
	chk_valid_held: assert property (s_stall |=> pix_valid)
		else $error("word withdrawn while stalled");
	chk_data_held: assert property (s_stall |=> $stable({pix_data, pix_frame_start, pix_line_start, pix_field}))
		else $error("word changed while stalled");
	chk_frame_line: assert property (pix_valid && pix_frame_start |-> pix_line_start)
		else $error("frame start without line start");
	chk_interlace_class: assert property (s_settled |-> interlaced == (source_class inside {2'h1, 2'h2}))
		else $error("interlaced status wrong");
	chk_unsup_orient: assert property (s_settled |-> unsupported == (portrait && source_class != 2'h0))
		else $error("unsupported status wrong");
	chk_unsup_quiet: assert property (s_settled ##0 unsupported |-> !pix_valid)
		else $error("word from unsupported source");
	chk_field_flat: assert property (s_settled ##0 (pix_valid && !bt656_mode && source_class == 2'h0) |-> !pix_field)
		else $error("field set for progressive source");
	chk_ovf_cause: assert property ($rose(overflow) |-> !$past(pix_ready, 2))
		else $error("overflow without stalled sink");
endmodule

/* File: video_source_model.sv */
module video_source_model (
	output logic pclk,
	output logic hsync_in,
	output logic vsync_in,
	output logic pixel_valid_in,
	output logic [video_capture_pkg::PIXEL_WIDTH-1:0] pixel_bus_in,
	input wire logic launch_on_rising,
	input wire logic hs_low,
	input wire logic vs_low
);
	timeunit 1ns;
	timeprecision 1ps;
	// 368 clocks at 12.5 MHz hold the line rate at 34 kHz
	localparam int LINE_CLOCKS = 368;
	logic hs_act = 1'b0;
	logic vs_act = 1'b0;
	logic [23:0] tx_q[$];
	// Sync polarity comes from hs_low and vs_low; the bench ties vs_low to what the capture side expects
	assign hsync_in = hs_act ^ hs_low;
	assign vsync_in = vs_act ^ vs_low;
	// Pixel clock runs free, off phase from the system clock
	initial
	begin
		pixel_valid_in = 1'b0;
		pixel_bus_in = 24'h000000;
		pclk = 1'b0;
		#7;
		forever #40 pclk = ~pclk;
	end
	// Outputs move just after the edge the capture side does not use
	task step();
		if (launch_on_rising)
			@(posedge pclk);
		else
			@(negedge pclk);
		#1;
	endtask
	// An idle bus shows the inverse of its last value
	task put(input logic [23:0] w, input logic v);
		step();
		pixel_bus_in = v ? w : ~pixel_bus_in;
		pixel_valid_in = v;
	endtask
	// Sync pulse, back porch, active run, front porch padded to the full line
	task hs_line(input int n, input logic strobe);
		step();
		hs_act = 1'b1;
		repeat (4) step();
		hs_act = 1'b0;
		repeat (4) put(24'h000000, 1'b0);
		for (int i = 0; i < n; i++)
			put(tx_q.size() != 0 ? tx_q.pop_front() : 24'h000000, strobe);
		repeat (LINE_CLOCKS - 9 - n) put(24'h000000, 1'b0);
	endtask
	task frame_sync();
		step();
		vs_act = 1'b1;
		hs_line(0, 1'b0);
		vs_act = 1'b0;
		hs_line(0, 1'b0);
	endtask
	function automatic logic [23:0] ref_word(input logic f, input logic h);
		return {16'h0000, 1'b1, f, 1'b0, h, h, f ^ h, f, f ^ h};
	endfunction
	task put_ref(input logic f, input logic h);
		put(24'h0000FF, 1'b1);
		repeat (2) put(24'h000000, 1'b1);
		put(ref_word(f, h), 1'b1);
	endtask
	// Embedded line: start code, payload, end code, blanking bytes
	task bt_line(input logic f, input int n);
		put_ref(f, 1'b0);
		repeat (n) put(tx_q.pop_front(), 1'b1);
		put_ref(f, 1'b1);
		repeat (LINE_CLOCKS - 8 - n) put(24'h000010, 1'b1);
	endtask
endmodule

/* File: parallel_video_input_capture_bench.sv */
module parallel_video_input_capture_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic capture_on_falling = 1'b0, hsync_active_low = 1'b0, vsync_active_low = 1'b0, src_hs_low = 1'b0;
	logic bt656_mode = 1'b0, use_valid_strobe = 1'b1, portrait = 1'b0, pix_ready = 1'b1, stall = 1'b0, count_only = 1'b0;
	logic [1:0] source_class = 2'h0;
	logic pclk, hsync_in, vsync_in, pixel_valid_in, pix_frame_start, pix_line_start, pix_field, pix_valid;
	logic overflow, unsupported, interlaced;
	logic [23:0] pixel_bus_in, pix_data;
	logic [26:0] exp_q[$];
	int seed = 27, errors = 0, total_checks = 0, words = 0, lines = 0;
	parallel_video_input_capture i_dut (.clk(clk), .rst_n(rst_n), .pclk(pclk), .hsync_in(hsync_in), .vsync_in(vsync_in),
		.pixel_valid_in(pixel_valid_in), .pixel_bus_in(pixel_bus_in), .capture_on_falling(capture_on_falling),
		.hsync_active_low(hsync_active_low), .vsync_active_low(vsync_active_low), .bt656_mode(bt656_mode),
		.use_valid_strobe(use_valid_strobe), .portrait(portrait), .source_class(source_class), .h_start(12'h006),
		.h_active(12'h005), .v_start(12'h003), .v_active(12'h002), .pix_data(pix_data), .pix_frame_start(pix_frame_start),
		.pix_line_start(pix_line_start), .pix_field(pix_field), .pix_valid(pix_valid), .pix_ready(pix_ready),
		.overflow(overflow), .unsupported(unsupported), .interlaced(interlaced));
	video_source_model i_src (.pclk(pclk), .hsync_in(hsync_in), .vsync_in(vsync_in), .pixel_valid_in(pixel_valid_in),
		.pixel_bus_in(pixel_bus_in), .launch_on_rising(capture_on_falling), .hs_low(src_hs_low), .vs_low(vsync_active_low));
	// Clock and a sink that stalls at random
	always #10 clk = ~clk;
	always @(posedge clk)
		pix_ready <= !stall && ({$random(seed)} % 4 != 0);
	task check_word(input string name, input logic [26:0] expv, input logic [26:0] got);
		total_checks++;
		if (got !== expv)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, expv, got);
		end
	endtask
	task check_val(input string name, input logic [31:0] expv, input logic [31:0] got);
		total_checks++;
		if (got !== expv)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, expv, got);
		end
	endtask
	// Accepted words are compared in order, or only counted
	always @(posedge clk)
	begin
		if ((rst_n && pix_valid && pix_ready) === 1'b1)
		begin
			words++;
			lines += pix_line_start;
			if (!count_only)
				check_word("word", exp_q.size() != 0 ? exp_q.pop_front() : 'x, {pix_field, pix_line_start, pix_frame_start, pix_data});
		end
	end
	// Random payload for the source, with its expected word when kept
	task queue_line(input int n, input logic fs, input logic field, input logic bt, input logic keep);
		logic [23:0] w;
		for (int i = 0; i < n; i++)
		begin
			w = bt ? {16'h0000, 8'(({$random(seed)} % 254) + 1)} : 24'($random(seed));
			i_src.tx_q.push_back(w);
			if (keep)
				exp_q.push_back({field, i == 0, fs && i == 0, w});
		end
	endtask
	task restart();
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (20) @(posedge clk);
		words = 0;
		lines = 0;
	endtask
	task drain(input string name);
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		repeat (20) @(posedge clk);
		check_val("left over", 32'h00000000, exp_q.size());
		$display("test %s done, errors %0d", name, errors);
	endtask
	function automatic logic [1:0] class_status(input int c, input int p);
		return {p != 0 && c != 0, c == 1 || c == 2};
	endfunction
	task results();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// About 35 lines of 29 us each; half as much again cuts a hang
	initial
	begin
		#1600us;
		errors++;
		results();
	end
	// --------
	// Scenarios
	// --------
	initial
	begin
		int n;
		@(posedge clk);
		restart();
		i_src.frame_sync();
		for (int l = 0; l < 3; l++)
		begin
			n = 1 + {$random(seed)} % 12;
			queue_line(n, l == 0, 1'b0, 1'b0, 1'b1);
			i_src.hs_line(n, 1'b1);
		end
		drain("rising edge");
		capture_on_falling <= 1'b1;
		hsync_active_low <= 1'b1;
		vsync_active_low <= 1'b1;
		src_hs_low <= 1'b1;
		restart();
		for (int f = 0; f < 2; f++)
		begin
			i_src.frame_sync();
			for (int l = 0; l < 2; l++)
			begin
				queue_line(5, l == 0, 1'b0, 1'b0, 1'b1);
				i_src.hs_line(5, 1'b1);
				@(posedge clk);
				hsync_active_low <= (f != 0 || l != 0);
			end
		end
		drain("falling edge");
		// The first embedded line may or may not open a frame, so it is only counted
		capture_on_falling <= 1'b0;
		hsync_active_low <= 1'b0;
		vsync_active_low <= 1'b0;
		src_hs_low <= 1'b0;
		bt656_mode <= 1'b1;
		count_only <= 1'b1;
		restart();
		queue_line(3, 1'b0, 1'b0, 1'b1, 1'b0);
		i_src.bt_line(1'b1, 3);
		count_only <= 1'b0;
		for (int l = 0; l < 3; l++)
		begin
			queue_line(4, l != 1, l == 2, 1'b1, 1'b1);
			i_src.bt_line(l == 2, 4);
		end
		drain("embedded timing");
		bt656_mode <= 1'b0;
		use_valid_strobe <= 1'b0;
		count_only <= 1'b1;
		restart();
		i_src.frame_sync();
		repeat (7) i_src.hs_line(20, 1'b0);
		repeat (40) @(posedge clk);
		check_val("auto words", 32'h0000000A, words);
		check_val("auto lines", 32'h00000002, lines);
		drain("auto framing");
		use_valid_strobe <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			for (int p = 0; p < 2; p++)
			begin
				source_class <= 2'(c);
				portrait <= 1'(p);
				restart();
				repeat (20) @(posedge clk);
				check_val("status", 32'(class_status(c, p)), {30'h00000000, unsupported, interlaced});
			end
		end
		i_src.frame_sync();
		i_src.hs_line(6, 1'b1);
		repeat (40) @(posedge clk);
		check_val("blocked words", 32'h00000000, words);
		drain("source classes");
		// Sink stalled across a long line fills the buffer until it refuses
		source_class <= 2'h0;
		portrait <= 1'b0;
		stall <= 1'b1;
		restart();
		i_src.frame_sync();
		i_src.hs_line(24, 1'b1);
		check_val("overflow set", 32'h00000001, 32'(overflow));
		stall <= 1'b0;
		repeat (60) @(posedge clk);
		count_only <= 1'b0;
		queue_line(3, 1'b1, 1'b0, 1'b0, 1'b1);
		i_src.frame_sync();
		i_src.hs_line(3, 1'b1);
		repeat (40) @(posedge clk);
		check_val("overflow clear", 32'h00000000, 32'(overflow));
		drain("overflow");
		results();
	end
endmodule

bind parallel_video_input_capture video_capture_properties i_chk (.clk(clk), .rst_n(rst_n), .bt656_mode(bt656_mode),
	.portrait(portrait), .source_class(source_class), .pix_data(pix_data), .pix_frame_start(pix_frame_start),
	.pix_line_start(pix_line_start), .pix_field(pix_field), .pix_valid(pix_valid), .pix_ready(pix_ready),
	.overflow(overflow), .unsupported(unsupported), .interlaced(interlaced));
